// File: verilog/mcw_cmd_seq.sv
// Media command sequencer: checks command order, keeps state, runs walker.
// Assumes an APB master on the same clock and a same-clock command source.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
`include "mcw_defines.svh"
module mcw_cmd_seq (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MCW_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [3:0] cmdOp,
  input wire logic [31:0] cmdData,
  output logic threadValid,
  input wire logic threadReady,
  output logic [`MCW_CW-1:0] threadX,
  output logic [`MCW_CW-1:0] threadY,
  output logic threadSlice
);
  mcw_walk_if wk ();
  mcw_pkg::mcw_op_e op;
  mcw_pkg::mcw_prim_e lastPrim_r;
  mcw_pkg::mcw_walk_cfg_s cfg_r;
  logic [`MCW_MODE_W-1:0] mode_r;
  logic [31:0] base_r, sysRoutine_r, feState_r, curbe_r, ifDesc_r;
  logic [31:0] barrier_r;
  logic [7:0] watermark_r, handleCnt_r, handleTarget_r;
  logic [`MCW_ERR_W-1:0] err_r, errSet, errClr;
  logic flushSeen_r, baseSeen_r, feSeen_r, idSeen_r, primLock_r;
  logic arbOn_r, mediaSel_r, startReq_r;
  logic take, isState, setupOk, wrEn, rdSetup, mapped;
  logic [31:0] rdData;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mcw_pkg::mcw_vec_s unpackVec(logic [31:0] d);
    mcw_pkg::mcw_vec_s v;
    v.x = d[`MCW_X_FLD];
    v.y = d[`MCW_Y_FLD];
    return v;
  endfunction

  function automatic logic [31:0] packVec(mcw_pkg::mcw_vec_s v);
    logic [31:0] d;
    d = 32'h0000_0000;
    d[`MCW_X_FLD] = v.x;
    d[`MCW_Y_FLD] = v.y;
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign op = mcw_pkg::mcw_op_e'(cmdOp);
  assign cmdReady = !wk.busy && !startReq_r;
  assign take = cmdValid && cmdReady;
  assign isState = op == mcw_pkg::OP_SYS_ROUTINE ||
                   op == mcw_pkg::OP_FRONT_END || op == mcw_pkg::OP_CURBE ||
                   op == mcw_pkg::OP_IF_DESC || op == mcw_pkg::OP_BARRIER;
  assign setupOk = baseSeen_r && feSeen_r && idSeen_r;

  // Sequence error detection, five bits, bit 0 shared by two misuses
  always_comb begin
    errSet = '0;
    if (take) begin
      errSet[0] = !flushSeen_r && op != mcw_pkg::OP_FLUSH; // see (R01)
      errSet[1] = isState && !baseSeen_r; // see (R03)
      errSet[2] = (op == mcw_pkg::OP_MEDIA_OBJ || op == mcw_pkg::OP_WALK ||
                   op == mcw_pkg::OP_PERSIST) && !setupOk; // see (R05)
      errSet[3] = (isState || op == mcw_pkg::OP_BASE_ADDR) && primLock_r;
      errSet[4] = (op == mcw_pkg::OP_COMPUTE &&
                   lastPrim_r == mcw_pkg::PRIM_MEDIA) ||
                  ((op == mcw_pkg::OP_MEDIA_OBJ || op == mcw_pkg::OP_WALK) &&
                   lastPrim_r == mcw_pkg::PRIM_COMPUTE); // see (R09)
      errSet[0] = errSet[0] | (op == mcw_pkg::OP_MEDIA_OBJ && !mediaSel_r &&
                               !flushSeen_r); // see (R02)
    end
  end

  // Sequence flags and primitive lock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flushSeen_r <= 1'b0;
      baseSeen_r <= 1'b0;
      feSeen_r <= 1'b0;
      idSeen_r <= 1'b0;
      primLock_r <= 1'b0;
      mediaSel_r <= 1'b0;
      lastPrim_r <= mcw_pkg::PRIM_NONE;
    end else if (take) begin
      case (op)
        mcw_pkg::OP_FLUSH: begin
          flushSeen_r <= 1'b1;
          primLock_r <= 1'b0;
          lastPrim_r <= mcw_pkg::PRIM_NONE;
        end
        mcw_pkg::OP_PIPE_SEL: mediaSel_r <= cmdData[0];
        mcw_pkg::OP_BASE_ADDR: baseSeen_r <= 1'b1;
        mcw_pkg::OP_FRONT_END: feSeen_r <= 1'b1;
        mcw_pkg::OP_IF_DESC: idSeen_r <= 1'b1;
        mcw_pkg::OP_FENCE: primLock_r <= 1'b0; // see (R07)
        mcw_pkg::OP_MEDIA_OBJ, mcw_pkg::OP_WALK, mcw_pkg::OP_PERSIST: begin
          primLock_r <= 1'b1;
          lastPrim_r <= mcw_pkg::PRIM_MEDIA;
        end
        mcw_pkg::OP_COMPUTE: begin
          primLock_r <= 1'b1;
          lastPrim_r <= mcw_pkg::PRIM_COMPUTE;
        end
        default: primLock_r <= primLock_r;
      endcase
    end
  end

  // State storage: newest command of each type overwrites
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      base_r <= 32'h0000_0000;
      sysRoutine_r <= 32'h0000_0000;
      feState_r <= 32'h0000_0000;
      curbe_r <= 32'h0000_0000;
      ifDesc_r <= 32'h0000_0000;
      barrier_r <= 32'h0000_0000;
      watermark_r <= 8'h00;
      arbOn_r <= 1'b1;
    end else if (take) begin
      case (op)
        mcw_pkg::OP_BASE_ADDR: base_r <= cmdData; // see (R04)
        mcw_pkg::OP_SYS_ROUTINE: sysRoutine_r <= cmdData;
        mcw_pkg::OP_FRONT_END: feState_r <= cmdData;
        mcw_pkg::OP_CURBE: curbe_r <= cmdData;
        mcw_pkg::OP_IF_DESC: ifDesc_r <= cmdData;
        mcw_pkg::OP_BARRIER: barrier_r <= cmdData;
        mcw_pkg::OP_FENCE: watermark_r <= cmdData[`MCW_WMARK_FLD];
        mcw_pkg::OP_ARB: arbOn_r <= cmdData[0]; // see (R08)
        default: base_r <= base_r;
      endcase
    end
  end

  // Return handles: discard on front-end state, then rebuild one a cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      handleCnt_r <= 8'h00;
      handleTarget_r <= 8'h00;
    end else if (take && op == mcw_pkg::OP_FRONT_END) begin
      handleCnt_r <= 8'h00; // see (R06)
      handleTarget_r <= cmdData[`MCW_HCNT_FLD];
    end else if (handleCnt_r < handleTarget_r) begin
      handleCnt_r <= handleCnt_r + 8'h01; // see (R06)
    end
  end

  // Walker launch from a walk command or from the control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      startReq_r <= 1'b0;
    end else if (startReq_r) begin
      startReq_r <= 1'b0;
    end else if ((take && op == mcw_pkg::OP_WALK) ||
                 (wrEn && paddr == `MCW_REG_CTRL &&
                  pwdata[`MCW_START_BIT] && !wk.busy)) begin
      startReq_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdSetup = psel && !penable;
  assign mapped = paddr <= `MCW_REG_HANDLE && paddr[1:0] == 2'b00;
  assign pslverr = psel && penable && !mapped;
  assign errClr = (wrEn && paddr == `MCW_REG_STATUS) ?
                  pwdata[`MCW_ERR_FLD] : '0;

  // Sticky errors, a new event beats a clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_r <= '0;
    end else begin
      err_r <= (err_r & ~errClr) | errSet;
    end
  end

  // Walker configuration registers, see (R11) (R16)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= '0;
      mode_r <= '0;
    end else if (wrEn) begin
      case (paddr)
        `MCW_REG_GRES: cfg_r.gRes <= unpackVec(pwdata);
        `MCW_REG_GSTART: cfg_r.gStart <= unpackVec(pwdata);
        `MCW_REG_GOUT: cfg_r.gOut <= unpackVec(pwdata);
        `MCW_REG_GIN: cfg_r.gIn <= unpackVec(pwdata);
        `MCW_REG_LRES: cfg_r.lRes <= unpackVec(pwdata);
        `MCW_REG_LSTART: cfg_r.lStart <= unpackVec(pwdata);
        `MCW_REG_LOUT: cfg_r.lOut <= unpackVec(pwdata);
        `MCW_REG_LIN: cfg_r.lIn <= unpackVec(pwdata);
        `MCW_REG_LMID: cfg_r.lMid <= unpackVec(pwdata);
        `MCW_REG_MODE: begin
          mode_r <= pwdata[`MCW_MODE_W-1:0];
          cfg_r.dual <= pwdata[`MCW_DUAL_BIT];
          cfg_r.extra <= pwdata[`MCW_EXTRA_FLD];
        end
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Read multiplexer
  always_comb begin
    rdData = 32'h0000_0000;
    case (paddr)
      `MCW_REG_STATUS: begin
        rdData[0] = wk.busy;
        rdData[`MCW_ERR_FLD] = err_r;
        rdData[6] = baseSeen_r;
        rdData[7] = feSeen_r;
        rdData[8] = idSeen_r;
        rdData[9] = handleCnt_r == handleTarget_r;
        rdData[10] = primLock_r;
        rdData[11] = arbOn_r;
      end
      `MCW_REG_GRES: rdData = packVec(cfg_r.gRes);
      `MCW_REG_GSTART: rdData = packVec(cfg_r.gStart);
      `MCW_REG_GOUT: rdData = packVec(cfg_r.gOut);
      `MCW_REG_GIN: rdData = packVec(cfg_r.gIn);
      `MCW_REG_LRES: rdData = packVec(cfg_r.lRes);
      `MCW_REG_LSTART: rdData = packVec(cfg_r.lStart);
      `MCW_REG_LOUT: rdData = packVec(cfg_r.lOut);
      `MCW_REG_LIN: rdData = packVec(cfg_r.lIn);
      `MCW_REG_LMID: rdData = packVec(cfg_r.lMid);
      `MCW_REG_MODE: rdData = {16'h0000, mode_r};
      `MCW_REG_BASE: rdData = base_r;
      `MCW_REG_FESTATE: rdData = feState_r;
      `MCW_REG_IFDESC: rdData = ifDesc_r ^ curbe_r ^ sysRoutine_r ^ barrier_r;
      `MCW_REG_HANDLE: rdData = {watermark_r, 8'h00, handleTarget_r,
                                 handleCnt_r};
      default: rdData = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // Walker and thread request port
  // ----------------------------------------------------------------
  assign wk.start = startReq_r;
  assign wk.cfg = cfg_r;
  assign wk.outReady = threadReady; // see (R20)
  assign threadValid = wk.outValid;
  assign threadX = wk.outPos.x;
  assign threadY = wk.outPos.y;
  assign threadSlice = wk.outSlice;

  mcw_walker u_walker (
    .clock(clock),
    .arst_n(arst_n),
    .wk(wk.walker)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fe_discard: assert property (@(posedge clock) disable iff (!arst_n)
    take && op == mcw_pkg::OP_FRONT_END |=> handleCnt_r == 8'h00) // see (R06)
    else $error("handles not discarded");

  a_base_newest: assert property (@(posedge clock) disable iff (!arst_n)
    take && op == mcw_pkg::OP_BASE_ADDR |=> base_r == $past(cmdData)) // see (R04)
    else $error("base state not overwritten");

  a_fence_unlock: assert property (@(posedge clock) disable iff (!arst_n)
    take && op == mcw_pkg::OP_FENCE |=> !primLock_r) // see (R07)
    else $error("fence left state locked");

  a_order_flag: assert property (@(posedge clock) disable iff (!arst_n)
    take && isState && !baseSeen_r |=> err_r[1]) // see (R03)
    else $error("order error not flagged");
endmodule

// File: verilog/mcw_defines.svh
// Constants of the media command sequencer and its block walker.
// Assumes inclusion by bare name from the package and the design modules.
//
// Notes on behaviour
// (R01) Source starts each sequence with a flush
// (R02) Pipe select skippable if media already selected; code flags a missing select only before the first flush
// (R03) Base-address state precedes other setup state
// (R04) Repeated state commands: newest one wins
// (R05) Setup needs base, front-end, descriptor commands
// (R06) Front-end state discards, regenerates return handles
// (R07) State fence unlocks pipelined state changes
// (R08) Source disables arbitration around barrier groups
// (R09) Flush separates compute and media primitives; code does not flag a persist command after compute
// (R10) Walker runs five nested loops with steps
// (R11) Each walker: resolution, start, outer, inner
// (R12) Coordinates are unitless, user-defined units
// (R13) Step components are signed
// (R14) Steps above one skip rows or columns
// (R15) Software walks blocks, not pixels
// (R16) Inner loop dual mode, extra middle steps
// (R17) Output equals global plus local position
// (R18) Middle loop bounded by extra step count
// (R19) Dual mode alternates between two half-walks
// (R20) One request per coordinate, stall when busy
`ifndef MCW_DEFINES_SVH
`define MCW_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and fields
// ----------------------------------------------------------------
`define MCW_CW 12
`define MCW_AW 8
`define MCW_X_FLD 11:0
`define MCW_Y_FLD 27:16
`define MCW_UNIT 12'sh001
`define MCW_ZERO 12'sh000
`define MCW_HCNT_FLD 7:0
`define MCW_HLEN_FLD 15:8
`define MCW_WMARK_FLD 7:0
`define MCW_DUAL_BIT 0
`define MCW_REPEL_BIT 1
`define MCW_ATTR_BIT 2
`define MCW_EXTRA_FLD 15:8
`define MCW_MODE_W 16
`define MCW_ERR_W 5
`define MCW_ERR_FLD 5:1
`define MCW_START_BIT 0

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCW_REG_CTRL 8'h00
`define MCW_REG_STATUS 8'h04
`define MCW_REG_GRES 8'h08
`define MCW_REG_GSTART 8'h0C
`define MCW_REG_GOUT 8'h10
`define MCW_REG_GIN 8'h14
`define MCW_REG_LRES 8'h18
`define MCW_REG_LSTART 8'h1C
`define MCW_REG_LOUT 8'h20
`define MCW_REG_LIN 8'h24
`define MCW_REG_LMID 8'h28
`define MCW_REG_MODE 8'h2C
`define MCW_REG_BASE 8'h30
`define MCW_REG_FESTATE 8'h34
`define MCW_REG_IFDESC 8'h38
`define MCW_REG_HANDLE 8'h3C

`endif

// File: verilog/mcw_pkg.sv
// Types shared by the command sequencer and the block walker.
// Assumes the constants header is on the include path.
`include "mcw_defines.svh"
package mcw_pkg;
  typedef logic signed [`MCW_CW-1:0] mcw_coord_t;

  typedef struct packed {
    mcw_coord_t x;
    mcw_coord_t y;
  } mcw_vec_s;

  typedef struct packed {
    mcw_vec_s gRes;
    mcw_vec_s gStart;
    mcw_vec_s gOut;
    mcw_vec_s gIn;
    mcw_vec_s lRes;
    mcw_vec_s lStart;
    mcw_vec_s lOut;
    mcw_vec_s lIn;
    mcw_vec_s lMid;
    logic dual;
    logic [7:0] extra;
  } mcw_walk_cfg_s;

  // Command opcodes seen on the command port
  typedef enum logic [3:0] {
    OP_FLUSH = 4'h0,
    OP_PIPE_SEL = 4'h1,
    OP_BASE_ADDR = 4'h2,
    OP_SYS_ROUTINE = 4'h3,
    OP_FRONT_END = 4'h4,
    OP_CURBE = 4'h5,
    OP_IF_DESC = 4'h6,
    OP_MEDIA_OBJ = 4'h7,
    OP_WALK = 4'h8,
    OP_FENCE = 4'h9,
    OP_COMPUTE = 4'hA,
    OP_BARRIER = 4'hB,
    OP_ARB = 4'hC,
    OP_PERSIST = 4'hD
  } mcw_op_e;

  typedef enum {PRIM_NONE, PRIM_MEDIA, PRIM_COMPUTE} mcw_prim_e;
endpackage

// File: verilog/mcw_walk_if.sv
// Link between the command sequencer and the block walker.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface mcw_walk_if;
  logic start;
  logic busy;
  mcw_pkg::mcw_walk_cfg_s cfg;
  logic outValid;
  logic outReady;
  mcw_pkg::mcw_vec_s outPos;
  logic outSlice;

  modport walker (input start, input cfg, input outReady,
    output busy, output outValid, output outPos, output outSlice);
  modport ctrl (output start, output cfg, output outReady,
    input busy, input outValid, input outPos, input outSlice);
endinterface

// File: verilog/mcw_walker.sv
// Five-level block walker producing one coordinate per request.
// Assumes a stable configuration while busy and a same-clock consumer.
`timescale 1ns/10ps
`include "mcw_defines.svh"
module mcw_walker (
  input wire logic clock,
  input wire logic arst_n,
  mcw_walk_if.walker wk
);
  mcw_pkg::mcw_vec_s go_r, gi_r, lo_r, lm_r, li_r, pos_r;
  mcw_pkg::mcw_vec_s go_nxt, gi_nxt, lo_nxt, lm_nxt, li_nxt, pos_nxt;
  logic [7:0] midCnt_r, midCnt_nxt;
  logic phase_r, phase_nxt, busy_r, done, fire;

  // ----------------------------------------------------------------
  // Vector helpers
  // ----------------------------------------------------------------
  function automatic mcw_pkg::mcw_vec_s vadd(mcw_pkg::mcw_vec_s a,
                                             mcw_pkg::mcw_vec_s b);
    mcw_pkg::mcw_vec_s s;
    s.x = a.x + b.x;
    s.y = a.y + b.y;
    return s;
  endfunction

  function automatic logic inBox(mcw_pkg::mcw_vec_s p,
                                 mcw_pkg::mcw_vec_s r);
    return p.x >= `MCW_ZERO && p.x < r.x && p.y >= `MCW_ZERO && p.y < r.y;
  endfunction

  // Horizontal mirror of a local position inside the block
  function automatic mcw_pkg::mcw_vec_s mirror(mcw_pkg::mcw_vec_s p,
                                               mcw_pkg::mcw_vec_s r);
    mcw_pkg::mcw_vec_s m;
    m.x = r.x - p.x - `MCW_UNIT;
    m.y = p.y;
    return m;
  endfunction

  // Inner loop goes on while in box and, in dual mode, converging
  function automatic logic innerOk(mcw_pkg::mcw_vec_s p,
                                   mcw_pkg::mcw_walk_cfg_s c);
    return inBox(p, c.lRes) && (!c.dual || mirror(p, c.lRes).x > p.x);
  endfunction

  assign fire = busy_r && wk.outReady;
  assign wk.busy = busy_r;
  assign wk.outValid = busy_r;
  assign wk.outPos = pos_r;
  assign wk.outSlice = phase_r;

  // ----------------------------------------------------------------
  // Loop advance chain, innermost level first
  // ----------------------------------------------------------------
  always_comb begin
    go_nxt = go_r;
    gi_nxt = gi_r;
    lo_nxt = lo_r;
    lm_nxt = lm_r;
    li_nxt = li_r;
    midCnt_nxt = midCnt_r;
    phase_nxt = 1'b0;
    done = 1'b0;
    if (wk.cfg.dual && !phase_r) begin
      phase_nxt = 1'b1; // Second half-walk takes its turn, see (R19)
    end else if (innerOk(vadd(li_r, wk.cfg.lIn), wk.cfg)) begin
      li_nxt = vadd(li_r, wk.cfg.lIn); // Signed steps, see (R13) (R14)
    end else if (midCnt_r < wk.cfg.extra &&
                 inBox(vadd(lm_r, wk.cfg.lMid), wk.cfg.lRes)) begin
      lm_nxt = vadd(lm_r, wk.cfg.lMid); // see (R18) (R16)
      li_nxt = lm_nxt;
      midCnt_nxt = midCnt_r + 8'h01;
    end else if (inBox(vadd(lo_r, wk.cfg.lOut), wk.cfg.lRes)) begin
      lo_nxt = vadd(lo_r, wk.cfg.lOut); // see (R10)
      lm_nxt = lo_nxt;
      li_nxt = lo_nxt;
      midCnt_nxt = 8'h00;
    end else begin
      lo_nxt = wk.cfg.lStart;
      lm_nxt = wk.cfg.lStart;
      li_nxt = wk.cfg.lStart;
      midCnt_nxt = 8'h00;
      if (inBox(vadd(gi_r, wk.cfg.gIn), wk.cfg.gRes)) begin
        gi_nxt = vadd(gi_r, wk.cfg.gIn); // see (R10) (R11)
      end else if (inBox(vadd(go_r, wk.cfg.gOut), wk.cfg.gRes)) begin
        go_nxt = vadd(go_r, wk.cfg.gOut);
        gi_nxt = go_nxt;
      end else begin
        done = 1'b1;
      end
    end
    // Emitted point is global plus local position, see (R17) (R12)
    pos_nxt = phase_nxt ? vadd(gi_nxt, mirror(li_nxt, wk.cfg.lRes))
                        : vadd(gi_nxt, li_nxt);
  end

  // Busy flag: start loads, final fire ends
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (!busy_r && wk.start) begin
      busy_r <= 1'b1;
    end else if (fire && done) begin
      busy_r <= 1'b0;
    end
  end

  // Loop positions, held while the consumer stalls, see (R20)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      go_r <= '0;
      gi_r <= '0;
      lo_r <= '0;
      lm_r <= '0;
      li_r <= '0;
      pos_r <= '0;
      midCnt_r <= 8'h00;
      phase_r <= 1'b0;
    end else if (!busy_r && wk.start) begin
      go_r <= wk.cfg.gStart;
      gi_r <= wk.cfg.gStart;
      lo_r <= wk.cfg.lStart;
      lm_r <= wk.cfg.lStart;
      li_r <= wk.cfg.lStart;
      pos_r <= vadd(wk.cfg.gStart, wk.cfg.lStart);
      midCnt_r <= 8'h00;
      phase_r <= 1'b0;
    end else if (fire && !done) begin
      go_r <= go_nxt;
      gi_r <= gi_nxt;
      lo_r <= lo_nxt;
      lm_r <= lm_nxt;
      li_r <= li_nxt;
      pos_r <= pos_nxt;
      midCnt_r <= midCnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence sLaunch;
    !busy_r && wk.start;
  endsequence

  sequence sStall;
    busy_r && !wk.outReady;
  endsequence

  a_launch_busy: assert property (@(posedge clock) disable iff (!arst_n)
    sLaunch |=> busy_r && midCnt_r == 8'h00) // see (R10)
    else $error("walker did not start");

  a_stall_holds: assert property (@(posedge clock) disable iff (!arst_n)
    sStall |=> busy_r && $stable(pos_r)) // see (R20)
    else $error("coordinate moved while stalled");

  a_sum_output: assert property (@(posedge clock) disable iff (!arst_n)
    busy_r && !phase_r |-> pos_r == vadd(gi_r, li_r)) // see (R17)
    else $error("output not global plus local");

  a_extra_bound: assert property (@(posedge clock) disable iff (!arst_n)
    busy_r |-> midCnt_r <= wk.cfg.extra) // see (R18)
    else $error("middle loop exceeded extra steps");

  a_dual_alternate: assert property (@(posedge clock) disable iff (!arst_n)
    fire && !done && wk.cfg.dual |=> phase_r != $past(phase_r)) // see (R19)
    else $error("dual mode did not alternate");

  a_inner_step: assert property (@(posedge clock) disable iff (!arst_n)
    fire && !wk.cfg.dual && innerOk(vadd(li_r, wk.cfg.lIn), wk.cfg)
    |=> li_r == vadd($past(li_r), wk.cfg.lIn)) // see (R13)
    else $error("inner step not applied");
endmodule

// File: verif/mcw_cmd_src.sv
// Command streamer model driving the command port.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/10ps
module mcw_cmd_src (
  input wire logic clock,
  input wire logic cmdReady,
  output logic cmdValid,
  output logic [3:0] cmdOp,
  output logic [31:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdOp = 4'hF;
    cmdData = 32'h0;
  end
  // Offer one word, hold it until taken, then leave one idle cycle
  task automatic send(input logic [3:0] op, input logic [31:0] d);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdData <= d;
    do @(posedge clock); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    cmdOp <= ~op;  // Released lines lose the old word
    cmdData <= ~d;
    @(posedge clock);
  endtask
endmodule

// File: verif/media_cmd_sequence_walker_tb_top.sv
// Random and directed bench for the command sequencer and walker.
// Assumes the design files and the command source model.
`timescale 1ns/10ps
module media_cmd_sequence_walker_tb_top;
  logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, threadReady = 1'b0, hold = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, cmdData, seed = 32'h6A8462ED;
  logic pready, pslverr, e, cmdValid, cmdReady, threadValid, threadSlice;
  logic [3:0] cmdOp;
  logic [11:0] threadX, threadY;
  logic [24:0] held, exp[$], got[$];
  int err_total = 0, checks_done = 0, v[16], n, dm, ex, sx, sy;
  always #4 clock = ~clock;
  mcw_cmd_seq DUT (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdData(cmdData), .threadValid(threadValid),
    .threadReady(threadReady), .threadX(threadX), .threadY(threadY),
    .threadSlice(threadSlice));
  mcw_cmd_src src (.clock(clock), .cmdReady(cmdReady),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit inb(int x, int y, int rx, int ry);
    return x >= 0 && y >= 0 && x < rx && y < ry;
  endfunction
  // Expected walk: global outer and inner, local outer, middle, inner
  function automatic void model();
    int gx, gy, lx, ly, ox, oy, px, py, mx, my, c;
    exp.delete();
    for (ox = v[2], oy = v[3]; inb(ox, oy, v[0], v[1]);
         ox += v[4], oy += v[5])
      for (gx = ox, gy = oy; inb(gx, gy, v[0], v[1]);
           gx += v[6], gy += v[7])
        for (px = v[10], py = v[11]; inb(px, py, v[8], v[9]);
             px += v[12], py += v[13])
          for (c = 0, mx = px, my = py; c <= ex && inb(mx, my, v[8], v[9]);
               c++, mx += sx, my += sy)
            for (lx = mx, ly = my; inb(lx, ly, v[8], v[9]) &&
                 ((lx == mx && ly == my) || !dm || v[8] - 1 - lx > lx);
                 lx += v[14], ly += v[15]) begin
              exp.push_back({1'b0, 12'(gx + lx), 12'(gy + ly)});
              if (dm)
                exp.push_back({1'b1, 12'(gx + v[8] - 1 - lx), 12'(gy + ly)});
            end
  endfunction
  task automatic chk(string s, logic [31:0] x, logic [31:0] y);
    checks_done++;
    if (y !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // APB master: setup, then access until pready at a rising edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Consumer stalling at random
  always @(posedge clock) threadReady <= xs() % 4 != 0;
  // Collects accepted points, checks stalled points hold
  always @(negedge clock) if (arst_n) begin
    if (hold) chk("held", held, {threadSlice, threadX, threadY});
    hold = threadValid === 1'b1 && threadReady === 1'b0;
    held = {threadSlice, threadX, threadY};
    if (threadValid === 1'b1 && threadReady === 1'b1) got.push_back(held);
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'hA00, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h80000000, {e, q[30:0]});
    src.send(mcw_pkg::OP_FRONT_END, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("order", 32'h6, q & 32'h6);
    apb(1'b1, 8'h04, 32'h3E);
    apb(1'b0, 8'h04, 32'h0);
    chk("clear", 32'h0, q & 32'h3E);
    src.send(mcw_pkg::OP_FLUSH, 32'h0);
    src.send(mcw_pkg::OP_PIPE_SEL, 32'h1);
    src.send(mcw_pkg::OP_BASE_ADDR, 32'h1000);
    src.send(mcw_pkg::OP_FRONT_END, 32'h0203);
    src.send(mcw_pkg::OP_FRONT_END, 32'h0305);
    src.send(mcw_pkg::OP_IF_DESC, 32'h55);
    src.send(mcw_pkg::OP_FENCE, 32'h07);
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h34, 32'h0);
    chk("fe", 32'h0305, q);
    apb(1'b0, 8'h3C, 32'h0);
    chk("handle", 32'h07000505, q & 32'hFF00FFFF);
    src.send(mcw_pkg::OP_ARB, 32'h0);
    src.send(mcw_pkg::OP_ARB, 32'h1);
    src.send(mcw_pkg::OP_FLUSH, 32'h0);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 16; k++) begin
        v[k] = k % 8 < 2 ? 1 + xs() % 3 : k % 8 < 4 ? xs() % v[k - 2]
          : int'(xs() % 5) - 2;
        if (k % 8 > 3 && k % 2 && v[k] == 0 && v[k - 1] == 0) v[k] = 1;
      end
      if (i == 0) v = '{1, 1, 0, 0, 1, 0, 0, 1, 2, 1, 0, 0, 0, 1, 1, 0};
      dm = i >= 4;
      ex = i % 3;
      sx = int'(xs() % 3) - 1;
      sy = int'(xs() % 3) - 1;
      apb(1'b1, 8'h28, {4'h0, 12'(sy), 4'h0, 12'(sx)});
      apb(1'b1, 8'h2C, {16'h0000, 8'(ex), 7'h00, 1'(dm)});
      for (int k = 0; k < 16; k += 2)
        apb(1'b1, 8'h08 + 8'(k * 2), {4'h0, 12'(v[k + 1]), 4'h0,
          12'(v[k])});
      model();
      if (i % 2)
        apb(1'b1, 8'h00, 32'h0000_0001);
      else
        src.send(mcw_pkg::OP_WALK, 32'h0);
      n = 0;
      while ((got.size() < exp.size() || threadValid !== 1'b0) && n++ < 3000)
        @(posedge clock);
      chk("idle", 32'h0, threadValid);
      chk("count", exp.size(), got.size());
      foreach (exp[j]) chk("coord", exp[j], got[j]);
      got.delete();
    end
    final_report();
  end
endmodule
